/* File: hdl/fmcrb_pkg.sv */
// Package: register map, field positions and reset values of the flash bank
package fmcrb_pkg;

  // Bank base in system space
  localparam logic [31:0] FMCRB_BASE = 32'h4000_0100;

  // Register byte offsets from the base
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_ADDR = 8'h0C;
  localparam logic [7:0] OFS_WDATA = 8'h10;
  localparam logic [7:0] OFS_TIMER = 8'h14;
  localparam logic [7:0] OFS_DIRTY = 8'h18;
  localparam logic [7:0] OFS_TICK = 8'h1C;
  localparam logic [7:0] OFS_CRC = 8'h20;
  localparam logic [7:0] OFS_REMAP = 8'h74;
  localparam logic [7:0] OFS_PROT = 8'h78;
  localparam logic [7:0] OFS_DBGP = 8'h7C;

  // Mode register field positions
  localparam int MODE_BOOT_BIT = 31;
  localparam int MODE_IDLE_BIT = 24;
  localparam int MODE_VERIFY_BIT = 23;
  localparam int MODE_BUS_BIT = 22;
  localparam int MODE_TRIM_ENTRY_BIT = 17;
  localparam int MODE_TRIM_BIT = 16;
  localparam int MODE_FLASH_ENTRY_BIT = 9;
  localparam int MODE_FLASH_BIT = 8;

  // Access key bytes
  localparam logic [7:0] KEY_LO = 8'h5A;
  localparam logic [7:0] KEY_HI = 8'hA5;

  // Reset values
  localparam logic [31:0] RST_MODE = 32'h0100_0000;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] RST_TIMER = 32'h0000_00BB;
  localparam logic [31:0] RST_DIRTY = 32'h0000_0000;
  localparam logic [31:0] RST_DBGP = 32'h0000_0001;
  localparam logic [31:0] RST_CRC = 32'hFFFF_FFFF;

  // CRC-32 polynomial (reflected) over read data
  localparam logic [31:0] CRC_POLY = 32'hEDB8_8320;

  // Register bus request
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } fmcrb_req_t;

  // Key detector states
  typedef enum logic [1:0] {
    KEY_IDLE = 2'b00,
    KEY_GOT_LO = 2'b01,
    KEY_GOT_HI = 2'b10
  } fmcrb_key_t;

endpackage : fmcrb_pkg

/* File: hdl/fmcrb_crc.sv */
// Module: CRC-32 accumulator over flash read words
`timescale 1ns/1ps
module fmcrb_crc
  import fmcrb_pkg::*;
(
  input wire logic core_clk, // System clock
  input wire logic rstn, // Async reset, active low
  input wire logic clear, // Restart accumulation
  input wire logic data_valid, // Read word present
  input wire logic [31:0] data, // Read word
  output logic [31:0] crc // Running checksum
);

  typedef struct packed {
    logic [31:0] crc;
  } fmcrb_crc_st_t;

  fmcrb_crc_st_t st;
  fmcrb_crc_st_t next_st;

  // Fold one word, bit serial in a loop; one word per cycle
  always_comb
  begin
    logic [31:0] c;
    c = st.crc;
    next_st = st;
    if (data_valid)
    begin
      for (int i = 0; i < 32; i++)
      begin
        c = (c[0] ^ data[i]) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
      next_st.crc = c;
    end
    if (clear)
    begin
      next_st.crc = RST_CRC;
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= '{crc: RST_CRC};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign crc = st.crc;

endmodule : fmcrb_crc

/* File: hdl/fmcrb_bank.sv */
// Module: flash controller register bank with mode key detection
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps

module fmcrb_bank
  import fmcrb_pkg::*;
(
  input wire logic core_clk, // System clock, 100 MHz
  input wire logic rstn, // Async reset, active low
  input wire logic [31:0] addr, // Byte address, system space
  input wire logic [31:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [31:0] rdata, // Read data, cycle after rd
  input wire logic boot_mode, // Boot status from system
  input wire logic rd_valid, // Flash read word valid
  input wire logic [31:0] rd_word, // Flash read word
  output logic [31:0] ctrl_out, // Control register
  output logic [31:0] prog_addr, // Program address
  output logic [31:0] prog_data, // Program write data
  output logic [31:0] timer_out, // Erase/program timer value
  output logic [31:0] page_prot, // Page protection mask
  output logic dbg_port_en, // Debug port enable
  output logic remap_clear, // Boot remap removed
  output logic flash_mode, // Flash mode active
  output logic trim_mode, // Trim mode active
  output logic verify_en, // Verify enable
  output logic bus_mode_en // Bus mode enable
);

  typedef struct packed {
    logic boot;
    logic verify;
    logic bus_mode;
    logic trim_entry;
    logic trim;
    logic flash_entry;
    logic flash;
    fmcrb_key_t key;
    logic [31:0] ctrl;
    logic [31:0] paddr;
    logic [31:0] pdata;
    logic [31:0] timer;
    logic [31:0] dirty;
    logic [31:0] tick;
    logic [31:0] remap;
    logic [31:0] prot;
    logic [31:0] dbgp;
    logic [31:0] rdata;
  } fmcrb_st_t;

  fmcrb_st_t st;
  fmcrb_st_t next_st;
  logic [31:0] crc_val;
  logic boot_s1;
  logic boot_s2;
  logic hit;
  logic [7:0] ofs;
  logic [31:0] mode_view;

  // Boot strap level comes from outside: two-stage synchroniser
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      boot_s1 <= 1'b0;
      boot_s2 <= 1'b0;
    end
    else
    begin
      boot_s1 <= boot_mode;
      boot_s2 <= boot_s1;
    end
  end

  // Checksum of read data lives in its own module
  fmcrb_crc u_crc (
    .core_clk(core_clk),
    .rstn(rstn),
    .clear(1'b0),
    .data_valid(rd_valid),
    .data(rd_word),
    .crc(crc_val)
  );

  // Window decode: only the 256-byte page at the base answers
  assign hit = (addr[31:8] == FMCRB_BASE[31:8]);
  assign ofs = addr[7:0];

  // Mode view: idle while neither flash nor trim mode is active, unused bits zero
  always_comb
  begin
    mode_view = 32'h0000_0000;
    mode_view[MODE_BOOT_BIT] = st.boot;
    mode_view[MODE_IDLE_BIT] = ~(st.flash | st.trim);
    mode_view[MODE_VERIFY_BIT] = st.verify;
    mode_view[MODE_BUS_BIT] = st.bus_mode;
    mode_view[MODE_TRIM_ENTRY_BIT] = st.trim_entry;
    mode_view[MODE_TRIM_BIT] = st.trim;
    mode_view[MODE_FLASH_ENTRY_BIT] = st.flash_entry;
    mode_view[MODE_FLASH_BIT] = st.flash;
  end

  // Next state: writes, key detector, tick counter, read mux
  always_comb
  begin
    next_st = st;
    next_st.boot = boot_s2;
    // Free-running tick; software cannot load it
    next_st.tick = st.tick + 32'h0000_0001;
    next_st.rdata = 32'h0000_0000;
    if (wr && hit)
    begin
      // Any writable register touched marks contents modified
      next_st.dirty = 32'h0000_0001;
      case (ofs)
        OFS_MODE:
        begin
          // Only verify and bus mode are software writable
          next_st.verify = wdata[MODE_VERIFY_BIT];
          next_st.bus_mode = wdata[MODE_BUS_BIT];
          // Key pair: second byte completes, a repeated first byte keeps waiting, anything else restarts
          case (st.key)
            KEY_GOT_LO:
            begin
              if (wdata[7:0] == KEY_HI)
              begin
                next_st.flash_entry = 1'b1;
                next_st.flash = 1'b1;
                next_st.trim_entry = 1'b0;
                next_st.trim = 1'b0;
                next_st.key = KEY_IDLE;
              end
              else if (wdata[7:0] == KEY_LO)
              begin
                next_st.key = KEY_GOT_LO;
              end
              else
              begin
                next_st.key = KEY_IDLE;
              end
            end
            KEY_GOT_HI:
            begin
              if (wdata[7:0] == KEY_LO)
              begin
                next_st.trim_entry = 1'b1;
                next_st.trim = 1'b1;
                next_st.flash_entry = 1'b0;
                next_st.flash = 1'b0;
                next_st.key = KEY_IDLE;
              end
              else if (wdata[7:0] == KEY_HI)
              begin
                next_st.key = KEY_GOT_HI;
              end
              else
              begin
                next_st.key = KEY_IDLE;
              end
            end
            default:
            begin
              // Fresh start; a non-key byte leaves the mode as it is
              if (wdata[7:0] == KEY_LO)
              begin
                next_st.key = KEY_GOT_LO;
              end
              else if (wdata[7:0] == KEY_HI)
              begin
                next_st.key = KEY_GOT_HI;
              end
              else
              begin
                next_st.key = KEY_IDLE;
              end
            end
          endcase
        end
        OFS_CTRL:
        begin
          next_st.ctrl = wdata;
        end
        OFS_ADDR:
        begin
          next_st.paddr = wdata;
        end
        OFS_WDATA:
        begin
          next_st.pdata = wdata;
        end
        OFS_TIMER:
        begin
          next_st.timer = wdata;
        end
        OFS_DIRTY:
        begin
          // Explicit write wins over the modified mark
          next_st.dirty = wdata;
        end
        OFS_REMAP:
        begin
          next_st.remap = wdata;
        end
        OFS_PROT:
        begin
          next_st.prot = wdata;
        end
        OFS_DBGP:
        begin
          next_st.dbgp = wdata;
        end
        default:
        begin
          // Tick, CRC and holes: write dropped
          next_st.dirty = st.dirty;
        end
      endcase
    end
    // Read data registered; unmapped offsets return zero
    if (rd && hit)
    begin
      case (ofs)
        OFS_MODE: next_st.rdata = mode_view;
        OFS_CTRL: next_st.rdata = st.ctrl;
        OFS_ADDR: next_st.rdata = st.paddr;
        OFS_WDATA: next_st.rdata = st.pdata;
        OFS_TIMER: next_st.rdata = st.timer;
        OFS_DIRTY: next_st.rdata = st.dirty;
        OFS_TICK: next_st.rdata = st.tick;
        OFS_CRC: next_st.rdata = crc_val;
        OFS_REMAP: next_st.rdata = st.remap;
        OFS_PROT: next_st.rdata = st.prot;
        OFS_DBGP: next_st.rdata = st.dbgp;
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register with documented reset values
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st.boot <= 1'b0;
      st.verify <= 1'b0;
      st.bus_mode <= 1'b0;
      st.trim_entry <= 1'b0;
      st.trim <= 1'b0;
      st.flash_entry <= 1'b0;
      st.flash <= 1'b0;
      st.key <= KEY_IDLE;
      st.ctrl <= RST_ZERO;
      st.paddr <= RST_ZERO;
      st.pdata <= RST_ZERO;
      st.timer <= RST_TIMER;
      st.dirty <= RST_DIRTY;
      st.tick <= RST_ZERO;
      st.remap <= RST_ZERO;
      st.prot <= RST_ZERO;
      st.dbgp <= RST_DBGP;
      st.rdata <= RST_ZERO;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs straight from state flops
  assign rdata = st.rdata;
  assign ctrl_out = st.ctrl;
  assign prog_addr = st.paddr;
  assign prog_data = st.pdata;
  assign timer_out = st.timer;
  assign page_prot = st.prot;
  assign dbg_port_en = st.dbgp[0];
  assign remap_clear = st.remap[0];
  assign flash_mode = st.flash;
  assign trim_mode = st.trim;
  assign verify_en = st.verify;
  assign bus_mode_en = st.bus_mode;

endmodule : fmcrb_bank

/* File: verification/fmcrb_bank_props.sv */
// Checker: bus and mode-key properties of the flash register bank
`timescale 1ns/1ps
module fmcrb_props
  import fmcrb_pkg::*;
(
  input wire logic core_clk, // Clock
  input wire logic rstn, // Reset, active low
  input wire logic [31:0] addr, // Byte address
  input wire logic [31:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  input wire logic [31:0] rdata, // Read data
  input wire logic [31:0] timer_out, // Timer value
  input wire logic [31:0] page_prot, // Page mask
  input wire logic remap_clear, // Remap removed
  input wire logic flash_mode, // Flash mode
  input wire logic trim_mode, // Trim mode
  input wire logic verify_en, // Verify enable
  input wire logic bus_mode_en // Bus mode enable
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // Decode helpers; key bytes only count on mode register writes
  wire logic pg = addr[31:8] == FMCRB_BASE[31:8];
  wire logic w_mode = wr && pg && addr[7:0] == OFS_MODE;
  wire logic k_lo = w_mode && wdata[7:0] == KEY_LO;
  wire logic k_hi = w_mode && wdata[7:0] == KEY_HI;

  property p_rd_idle;
    rdata != 32'h0000_0000 |-> $past(rd);
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read slot");
  property p_timer;
    wr && pg && addr[7:0] == OFS_TIMER |=> timer_out == $past(wdata);
  endproperty
  a_timer: assert property (p_timer)
    else $error("timer write lost");
  property p_prot;
    wr && pg && addr[7:0] == OFS_PROT |=> page_prot == $past(wdata);
  endproperty
  a_prot: assert property (p_prot)
    else $error("protect write lost");
  property p_remap;
    wr && pg && addr[7:0] == OFS_REMAP |=> remap_clear == $past(wdata[0]);
  endproperty
  a_remap: assert property (p_remap)
    else $error("remap write lost");
  property p_mode_rw;
    w_mode |=> {verify_en, bus_mode_en} == $past(wdata[23:22]);
  endproperty
  a_mode_rw: assert property (p_mode_rw)
    else $error("mode control bits wrong");
  // Key pair back to back, or with one cycle between free of mode writes
  property p_flash;
    k_hi && ($past(k_lo) || ($past(k_lo, 2) && !$past(w_mode)))
      |=> flash_mode && !trim_mode;
  endproperty
  a_flash: assert property (p_flash)
    else $error("flash key not taken");
  property p_trim;
    k_lo && ($past(k_hi) || ($past(k_hi, 2) && !$past(w_mode)))
      |=> trim_mode && !flash_mode;
  endproperty
  a_trim: assert property (p_trim)
    else $error("trim key not taken");
  property p_flash_rise;
    $rose(flash_mode) |-> $past(k_hi);
  endproperty
  a_flash_rise: assert property (p_flash_rise)
    else $error("flash mode without key");
  property p_page;
    wr && !pg |=> $stable(page_prot);
  endproperty
  a_page: assert property (p_page)
    else $error("foreign write took effect");
endmodule : fmcrb_props

bind fmcrb_bank fmcrb_props u_props (.core_clk, .rstn, .addr, .wdata,
  .wr, .rd, .rdata, .timer_out, .page_prot, .remap_clear, .flash_mode,
  .trim_mode, .verify_en, .bus_mode_en);

/* File: verification/tb.sv */
// Testbench: register access, reset values and mode key sequences
`timescale 1ns/1ps
module tb
  import fmcrb_pkg::*;
;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [31:0] addr = 32'h0000_0000;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic boot_mode = 1'b0;
  logic rd_valid = 1'b0;
  logic [31:0] rd_word = 32'h0000_0000;
  logic [31:0] rdata, ctrl_out, prog_addr, prog_data, timer_out, page_prot;
  logic dbg_port_en, remap_clear, flash_mode, trim_mode, verify_en;
  logic bus_mode_en;
  logic [31:0] q, t0;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  logic [7:0] ofs [10] = '{OFS_MODE, OFS_CTRL, OFS_ADDR, OFS_WDATA,
    OFS_TIMER, OFS_DIRTY, OFS_REMAP, OFS_PROT, OFS_DBGP, OFS_CRC};
  logic [31:0] rv [10] = '{32'h0100_0000, 0, 0, 0, 32'h0000_00BB, 0, 0, 0,
    32'h0000_0001, 32'hFFFF_FFFF};

  fmcrb_bank dut (.core_clk, .rstn, .addr, .wdata, .wr, .rd, .rdata,
    .boot_mode, .rd_valid, .rd_word, .ctrl_out, .prog_addr, .prog_data,
    .timer_out, .page_prot, .dbg_port_en, .remap_clear, .flash_mode,
    .trim_mode, .verify_en, .bus_mode_en);

  // Free running 100 MHz clock
  initial
    forever #5 core_clk = ~core_clk;

  task automatic stop_test;
    $display("checks %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  // Hang guard, far above the roughly 140 cycles the run needs
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      n_errors++;
      stop_test();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One strobe per call, then one idle cycle; read data lives only in
  // the cycle after the strobe, so it is taken there at the falling edge
  task automatic bus(input logic w, input logic [31:0] a, d);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge core_clk);
    wr <= 1'b0;
    rd <= 1'b0;
    @(negedge core_clk);
    q = rdata;
    @(posedge core_clk);
  endtask : bus

  task automatic wreg(input logic [7:0] o, input logic [31:0] d);
    bus(1'b1, {FMCRB_BASE[31:8], o}, d);
  endtask : wreg

  task automatic rchk(input logic [7:0] o, input logic [31:0] e);
    bus(1'b0, {FMCRB_BASE[31:8], o}, 32'h0000_0000);
    chk($sformatf("reg %h", o), q, e);
  endtask : rchk

  // Key writes keep verify and bus mode set
  task automatic key(input logic [7:0] b);
    wreg(OFS_MODE, {16'h00C0, 8'h00, b});
  endtask : key

  function automatic logic [31:0] pat(input int i);
    return {24'h3C_5A96, 3'b000, i[3:0], 1'b1};
  endfunction : pat

  // Reflected CRC, LSB first, no final inversion
  function automatic logic [31:0] crc_step(input logic [31:0] c, d);
    for (int i = 0; i < 32; i++)
      c = (c >> 1) ^ ((c[0] ^ d[i]) ? CRC_POLY : 32'h0000_0000);
    return c;
  endfunction : crc_step

  initial
  begin
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 10; i++)
      rchk(ofs[i], rv[i]);
    rchk(8'h40, 32'h0000_0000);
    chk("dbg", 32'(dbg_port_en), 32'h0000_0001);
    for (int i = 1; i < 9; i++)
    begin
      wreg(ofs[i], pat(i));
      rchk(ofs[i], pat(i));
    end
    rchk(OFS_DIRTY, 32'h0000_0001);
    chk("timer", timer_out, pat(4));
    chk("ctrl", ctrl_out, pat(1));
    chk("paddr", prog_addr, pat(2));
    chk("pdata", prog_data, pat(3));
    wreg(OFS_DBGP, 32'h0000_0000);
    chk("dbg", 32'(dbg_port_en), 32'h0000_0000);
    chk("remap", 32'(remap_clear), 32'h0000_0001);
    bus(1'b1, 32'h4000_0278, 32'h0000_0000);
    chk("prot", page_prot, pat(7));
    // Tick is free running; each access takes two cycles, so two
    // accesses apart the sampled tick has moved by four
    bus(1'b0, {FMCRB_BASE[31:8], OFS_TICK}, 32'h0000_0000);
    t0 = q;
    wreg(OFS_TICK, 32'hFFFF_FFFF);
    rchk(OFS_TICK, t0 + 32'h0000_0004);
    rd_valid <= 1'b1;
    rd_word <= 32'h1234_5678;
    @(posedge core_clk);
    rd_valid <= 1'b0;
    wreg(OFS_CRC, 32'h0000_0000);
    rchk(OFS_CRC, crc_step(32'hFFFF_FFFF, 32'h1234_5678));
    wreg(OFS_MODE, 32'hFFFF_FFFF);
    rchk(OFS_MODE, 32'h01C0_0000);
    key(8'h5A);
    key(8'h33);
    key(8'hA5);
    rchk(OFS_MODE, 32'h01C0_0000);
    key(8'hA5);
    key(8'h5A);
    rchk(OFS_MODE, 32'h00C3_0000);
    key(8'h5A);
    key(8'h5A);
    key(8'hA5);
    rchk(OFS_MODE, 32'h00C0_0300);
    chk("modes", 32'({flash_mode, trim_mode}), 32'h0000_0002);
    chk("vb", 32'({verify_en, bus_mode_en}), 32'h0000_0003);
    // Second reset with boot status raised
    boot_mode <= 1'b1;
    rstn <= 1'b0;
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge core_clk);
    rchk(OFS_MODE, 32'h8100_0000);
    stop_test();
  end
endmodule : tb
